// file: common/pwsq_pkg.sv
// Purpose: constants shared by the periodic wake power sequencer
// Assumes: 20 MHz system clock, all timers step on a 1 ms tick
// Notes:   times are given in their own unit and turned into counts here
package pwsq_pkg;
    // ---------------------------------------------------------------
    // clock and tick
    // ---------------------------------------------------------------
    localparam int unsigned CLOCK_HZ      = 20_000_000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;
    localparam int unsigned DIV_W         = 16;
    localparam int unsigned MS_W          = 16;
    localparam int unsigned PERIOD_W      = 32;

    // ---------------------------------------------------------------
    // timing figures in milliseconds, grace time also given in seconds
    // ---------------------------------------------------------------
    localparam logic [15:0] MIN_ON_TIME_MS      = 16'h0008;  // 8 ms
    localparam logic [15:0] MIN_REST_TIME_MS    = 16'h0080;  // 128 ms
    localparam int unsigned SHUTDOWN_GRACE_S    = 1;
    localparam logic [15:0] SHUTDOWN_GRACE_MS   = 16'(SHUTDOWN_GRACE_S * MS_PER_S);
    localparam logic [15:0] DEBOUNCE_MS         = 16'h0020;  // 32 ms
    localparam logic [15:0] HOLD_MIN_MS         = 16'h0080;  // 128 ms
    localparam logic [15:0] HOLD_MAX_MS         = 16'h4010;  // 16.4 s

    // ---------------------------------------------------------------
    // sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_AWAKE,
        ST_SLEEP,
        ST_SHUTTING_OFF,
        ST_OFF
    } pwsq_state_e;
endpackage

// file: verilog/pwsq_sequencer.sv
// Purpose: wake timer state machine switching power to an attached system
// Assumes: configuration inputs are quasi-static; button and sleep are pins
// Notes:   open-drain pins drive low while their enable is high
//
// Overview of operation
// - active-high variant raises enable on recognised press or wake interval expiry.
// - enable is held low while sleeping in the active-high variant.
// - inverted variant: enable high while sleeping, low when woken.
// - sleep high or button low beyond hold time enters shutdown; 128ms..16.4s.
// - every run-to-shutdown passage pulls the warning low for one second.
// - leaving shutdown pulls startup notice low while enable stays asserted.
// - without a configured awake limit, awake time is limited to 8ms.
// - debounced button output follows debounced button level, open-drain low.
// - sleep request counts only in run mode, ignored during shutdown.
// - falling sleep edge while awake drops enable and enters sleep.
// - sleep request high while sleeping returns to awake, enable asserted.
// - low button level is a press; idle level is high.
// - sleep edges and awake limit are ignored for 8ms after waking.
// - sleep lasts at least 128ms, all wake triggers ignored meanwhile.
// - awake limit expiry returns to sleep regardless of sleep request.
// - a short press in shutdown returns the device to run mode.
`timescale 1ns/1ps
module pwsq_sequencer #(
    parameter int unsigned CYCLES_PER_MS     = pwsq_pkg::CYCLES_PER_MS,
    parameter bit          ENABLE_ACTIVE_LOW = 1'b0,
    parameter bit          START_IN_SHUTDOWN = 1'b0
) (
    input  wire logic        clock,               // 20 MHz clock
    input  wire logic        rst_n,               // async reset, active low
    input  wire logic        buttonN,             // pushbutton pin, low = pressed
    input  wire logic        sleepReq,            // sleep request pin from system
    input  wire logic [31:0] wakeIntervalMs,      // wake interval in ms
    input  wire logic [15:0] shutdownHoldMs,      // long-hold time in ms
    input  wire logic [15:0] onTimeLimitMs,       // awake limit in ms, 0 or below 8 = 8 ms
    output logic             enable,              // power enable, polarity per parameter
    output logic             debouncedButtonOut,  // open-drain level, always low
    output logic             debouncedButtonOe,   // high while pulling low
    output logic             startupNoticeNOut,   // open-drain level, always low
    output logic             startupNoticeNOe,    // high while pulling low
    output logic             shutdownWarningNOut, // open-drain level, always low
    output logic             shutdownWarningNOe   // high while pulling low
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] satInc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    // ---------------------------------------------------------------
    // millisecond tick divider
    // ---------------------------------------------------------------
    logic [15:0] divCnt_r, divCnt_nxt;
    logic        msTick_r, msTick_nxt;

    always_comb begin
        msTick_nxt = 1'b0;
        divCnt_nxt = divCnt_r + 16'h0001;
        if (divCnt_r == 16'(CYCLES_PER_MS - 1)) begin
            divCnt_nxt = 16'h0000;
            msTick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_r <= 16'h0000;
            msTick_r <= 1'b0;
        end else begin
            divCnt_r <= divCnt_nxt;
            msTick_r <= msTick_nxt;
        end
    end

    // ---------------------------------------------------------------
    // pin synchronisers and button debounce
    // ---------------------------------------------------------------
    logic        btnMeta_r, btnSync_r, slpMeta_r, slpSync_r, slpPrev_r;
    logic        btnDeb_r, btnDeb_nxt;
    logic [15:0] dbMs_r, dbMs_nxt;
    logic        pressEvt;

    always_comb begin
        btnDeb_nxt = btnDeb_r;
        dbMs_nxt   = dbMs_r;
        if (btnSync_r == btnDeb_r) begin
            dbMs_nxt = 16'h0000;
        end else if (msTick_r) begin
            if (dbMs_r == pwsq_pkg::DEBOUNCE_MS - 16'h0001) begin
                btnDeb_nxt = btnSync_r;
                dbMs_nxt   = 16'h0000;
            end else begin
                dbMs_nxt = satInc(dbMs_r);
            end
        end
        pressEvt = btnDeb_r & ~btnDeb_nxt;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            btnMeta_r <= 1'b1;
            btnSync_r <= 1'b1;
            slpMeta_r <= 1'b0;
            slpSync_r <= 1'b0;
            slpPrev_r <= 1'b0;
            btnDeb_r  <= 1'b1;
            dbMs_r    <= 16'h0000;
        end else begin
            btnMeta_r <= buttonN;
            btnSync_r <= btnMeta_r;
            slpMeta_r <= sleepReq;
            slpSync_r <= slpMeta_r;
            slpPrev_r <= slpSync_r;
            btnDeb_r  <= btnDeb_nxt;
            dbMs_r    <= dbMs_nxt;
        end
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    pwsq_pkg::pwsq_state_e state_r, state_nxt;
    logic [15:0] stateMs_r, stateMs_nxt;
    logic [31:0] periodMs_r, periodMs_nxt;
    logic [15:0] holdMs_r, holdMs_nxt;
    logic        powered_r, powered_nxt;
    logic        notice_r, notice_nxt;
    logic        enable_nxt, offOe_nxt;
    logic [15:0] holdLimit, onLimit;
    logic        runMode, holdExpired, sleepFall, minOnDone, minRestDone;

    always_comb begin
        // clamped configuration; out-of-range hold values pin to the ends
        holdLimit = shutdownHoldMs;
        if (shutdownHoldMs < pwsq_pkg::HOLD_MIN_MS) holdLimit = pwsq_pkg::HOLD_MIN_MS;
        if (shutdownHoldMs > pwsq_pkg::HOLD_MAX_MS) holdLimit = pwsq_pkg::HOLD_MAX_MS;
        onLimit = (onTimeLimitMs < pwsq_pkg::MIN_ON_TIME_MS) ? pwsq_pkg::MIN_ON_TIME_MS : onTimeLimitMs;

        runMode     = (state_r == pwsq_pkg::ST_AWAKE) || (state_r == pwsq_pkg::ST_SLEEP);
        holdExpired = runMode && (holdMs_r >= holdLimit);
        sleepFall   = slpPrev_r & ~slpSync_r;
        minOnDone   = stateMs_r >= pwsq_pkg::MIN_ON_TIME_MS;
        minRestDone = stateMs_r >= pwsq_pkg::MIN_REST_TIME_MS;

        state_nxt    = state_r;
        powered_nxt  = powered_r;
        notice_nxt   = notice_r;
        stateMs_nxt  = msTick_r ? satInc(stateMs_r) : stateMs_r;
        periodMs_nxt = (runMode && msTick_r && periodMs_r != 32'hffffffff) ? periodMs_r + 32'h1 : periodMs_r;
        // sleep request only counts toward the hold in run mode
        if (runMode && (slpSync_r || !btnDeb_r)) begin
            holdMs_nxt = msTick_r ? satInc(holdMs_r) : holdMs_r;
        end else begin
            holdMs_nxt = 16'h0000;
        end

        unique case (state_r)
            pwsq_pkg::ST_AWAKE: begin
                if (holdExpired) begin
                    state_nxt = pwsq_pkg::ST_SHUTTING_OFF;
                end else if (minOnDone && (sleepFall || stateMs_r >= onLimit)) begin
                    state_nxt = pwsq_pkg::ST_SLEEP;
                end
            end
            pwsq_pkg::ST_SLEEP: begin
                if (holdExpired) begin
                    state_nxt = pwsq_pkg::ST_SHUTTING_OFF;
                end else if (minRestDone &&
                             (periodMs_r >= wakeIntervalMs || pressEvt || slpSync_r)) begin
                    state_nxt = pwsq_pkg::ST_AWAKE;
                end
            end
            pwsq_pkg::ST_SHUTTING_OFF: begin
                // enable keeps its prior value through the grace time
                if (stateMs_r >= pwsq_pkg::SHUTDOWN_GRACE_MS) begin
                    state_nxt = pwsq_pkg::ST_OFF;
                end
            end
            pwsq_pkg::ST_OFF: begin
                // sleep request ignored; only a fresh press leaves
                if (pressEvt) begin
                    state_nxt  = pwsq_pkg::ST_AWAKE;
                    notice_nxt = 1'b1;
                end
            end
            default: state_nxt = pwsq_pkg::ST_OFF;
        endcase

        if (state_nxt != state_r) begin
            stateMs_nxt = 16'h0000;
            holdMs_nxt  = 16'h0000;
            unique case (state_nxt)
                pwsq_pkg::ST_AWAKE: begin
                    powered_nxt  = 1'b1;
                    periodMs_nxt = 32'h0;
                end
                pwsq_pkg::ST_SLEEP:        powered_nxt = 1'b0;
                pwsq_pkg::ST_OFF:          powered_nxt = 1'b0;
                pwsq_pkg::ST_SHUTTING_OFF: powered_nxt = powered_r;
                default:                   powered_nxt = 1'b0;
            endcase
        end
        if (!powered_nxt) notice_nxt = 1'b0;

        enable_nxt = powered_nxt ^ ENABLE_ACTIVE_LOW;
        offOe_nxt  = (state_nxt == pwsq_pkg::ST_SHUTTING_OFF);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r             <= START_IN_SHUTDOWN ? pwsq_pkg::ST_OFF : pwsq_pkg::ST_SLEEP;
            stateMs_r           <= 16'h0000;
            periodMs_r          <= 32'h0;
            holdMs_r            <= 16'h0000;
            powered_r           <= 1'b0;
            notice_r            <= 1'b0;
            enable              <= ENABLE_ACTIVE_LOW;
            debouncedButtonOe   <= 1'b0;
            startupNoticeNOe    <= 1'b0;
            shutdownWarningNOe  <= 1'b0;
            debouncedButtonOut  <= 1'b0;
            startupNoticeNOut   <= 1'b0;
            shutdownWarningNOut <= 1'b0;
        end else begin
            state_r             <= state_nxt;
            stateMs_r           <= stateMs_nxt;
            periodMs_r          <= periodMs_nxt;
            holdMs_r            <= holdMs_nxt;
            powered_r           <= powered_nxt;
            notice_r            <= notice_nxt;
            enable              <= enable_nxt;
            debouncedButtonOe   <= ~btnDeb_nxt;
            startupNoticeNOe    <= notice_nxt;
            shutdownWarningNOe  <= offOe_nxt;
            debouncedButtonOut  <= 1'b0;
            startupNoticeNOut   <= 1'b0;
            shutdownWarningNOut <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_sleep_enable_off: assert property (state_r == pwsq_pkg::ST_SLEEP |-> enable == ENABLE_ACTIVE_LOW)
        else $error("enable asserted while sleeping");
    a_wake_enable_on: assert property ($rose(state_r == pwsq_pkg::ST_AWAKE) |-> enable != ENABLE_ACTIVE_LOW)
        else $error("enable not asserted on wake");
    a_min_on_hold: assert property ((state_r == pwsq_pkg::ST_AWAKE) && !minOnDone && !holdExpired
        |=> state_r == pwsq_pkg::ST_AWAKE)
        else $error("left awake before minimum on time");
    a_min_rest_hold: assert property ((state_r == pwsq_pkg::ST_SLEEP) && !minRestDone && !holdExpired
        |=> state_r == pwsq_pkg::ST_SLEEP)
        else $error("left sleep before minimum rest time");
    a_limit_to_sleep: assert property ((state_r == pwsq_pkg::ST_AWAKE) && minOnDone && stateMs_r >= onLimit
        && !holdExpired |=> state_r == pwsq_pkg::ST_SLEEP)
        else $error("awake limit did not end awake state");
    a_edge_to_sleep: assert property ((state_r == pwsq_pkg::ST_AWAKE) && minOnDone && sleepFall && !holdExpired
        |=> state_r == pwsq_pkg::ST_SLEEP ##0 enable == ENABLE_ACTIVE_LOW)
        else $error("sleep edge ignored");
    a_high_wakes: assert property ((state_r == pwsq_pkg::ST_SLEEP) && minRestDone && slpSync_r && !holdExpired
        |=> state_r == pwsq_pkg::ST_AWAKE)
        else $error("sleep high did not wake");
    a_hold_warns: assert property (holdExpired |=> shutdownWarningNOe [*8])
        else $error("long hold did not start shutdown warning");
    a_grace_length: assert property (shutdownWarningNOe && (stateMs_r < pwsq_pkg::SHUTDOWN_GRACE_MS)
        |=> shutdownWarningNOe)
        else $error("warning ended early");
    a_off_stays: assert property ((state_r == pwsq_pkg::ST_OFF) && !pressEvt |=> state_r == pwsq_pkg::ST_OFF)
        else $error("left shutdown without a press");
    a_press_resumes: assert property ((state_r == pwsq_pkg::ST_OFF) && pressEvt
        |=> state_r == pwsq_pkg::ST_AWAKE && startupNoticeNOe)
        else $error("press did not resume run with notice");
    a_notice_needs_on: assert property (startupNoticeNOe |-> enable != ENABLE_ACTIVE_LOW)
        else $error("startup notice without enable");
    a_button_track: assert property ($fell(btnDeb_r) |-> debouncedButtonOe && $past(debouncedButtonOe) == 1'b0)
        else $error("debounced output not tracking");
    a_period_restart: assert property ($rose(state_r == pwsq_pkg::ST_AWAKE) |-> periodMs_r == 32'h0
        && stateMs_r == 16'h0000)
        else $error("counters not restarted on wake");

    c_periodic_wake: cover property ((state_r == pwsq_pkg::ST_SLEEP) ##1 (state_r == pwsq_pkg::ST_AWAKE));
    c_sleep_edge: cover property ((state_r == pwsq_pkg::ST_AWAKE) && sleepFall && minOnDone);
    c_shutdown: cover property ((state_r == pwsq_pkg::ST_SHUTTING_OFF) ##1 (state_r == pwsq_pkg::ST_OFF));
    c_resume: cover property ((state_r == pwsq_pkg::ST_OFF) ##1 (state_r == pwsq_pkg::ST_AWAKE));
endmodule // pwsq_sequencer

// file: verification/pwsq_host_model.sv
// Purpose: behavioural host that drives the sleep request pin
// Assumes: host wakes with enable; taskMs of 0 means a passive host
// Notes:   pin is push-pull, so it sits low when the host is idle
`timescale 1ns/1ps
module pwsq_host_model #(
    parameter int CPM = 4
) (
    input  wire logic        clock,    // system clock
    input  wire logic        enable,   // power enable, active high
    input  wire logic [15:0] taskMs,   // task length in ms, 0 = passive
    input  wire logic        nudge,    // asks for a 2 ms high pulse
    output logic             sleepReq  // sleep request pin
);
    logic taskLvl;   // level from the task sequence
    logic nudgeLvl;  // level from a nudge pulse

    // two sources share the pin; the bench never lets them overlap
    assign sleepReq = taskLvl | nudgeLvl;

    task automatic waitMs(input int n);
        repeat (n * CPM) @(posedge clock);
        #2;
    endtask

    initial begin
        taskLvl = 1'b0;
        forever begin
            @(posedge enable);
            if (taskMs != 16'h0000) begin
                // early toggles land inside the minimum on time
                waitMs(2);
                taskLvl = 1'b1;
                waitMs(2);
                taskLvl = 1'b0;
                waitMs(2);
                taskLvl = 1'b1;
                waitMs(int'(taskMs) - 6);
                taskLvl = 1'b0;
            end
        end
    end

    initial begin
        nudgeLvl = 1'b0;
        forever begin
            @(posedge nudge);
            @(posedge clock);
            #2;
            nudgeLvl = 1'b1;
            waitMs(2);
            nudgeLvl = 1'b0;
        end
    end
endmodule // pwsq_host_model

// file: verification/periodic_wake_power_sequencer_tb_top.sv
// Purpose: self-checking bench for the wake timer sequencer
// Assumes: 4 clocks per ms tick so long timers stay short
// Notes:   times are measured in whole ticks from the bench side
`timescale 1ns/1ps
module periodic_wake_power_sequencer_tb_top;
    localparam int CPM = 4;
    logic        clock;
    logic        rst_n;
    logic        buttonN;
    logic        sleepReq;
    logic        nudge;
    logic [31:0] wakeIntervalMs;
    logic [15:0] shutdownHoldMs;
    logic [15:0] onTimeLimitMs;
    logic [15:0] taskMs;
    logic        enable, enableInv, enableOff, btnOut, btnOe, noticeOut, noticeOe, warnOut, warnOe;
    int          error_cnt = 0;
    int          compares  = 0;
    int          t1, t2;

    pwsq_sequencer #(.CYCLES_PER_MS(CPM)) uut (.clock(clock), .rst_n(rst_n), .buttonN(buttonN),
        .sleepReq(sleepReq), .wakeIntervalMs(wakeIntervalMs), .shutdownHoldMs(shutdownHoldMs),
        .onTimeLimitMs(onTimeLimitMs), .enable(enable), .debouncedButtonOut(btnOut),
        .debouncedButtonOe(btnOe), .startupNoticeNOut(noticeOut), .startupNoticeNOe(noticeOe),
        .shutdownWarningNOut(warnOut), .shutdownWarningNOe(warnOe));
    // inverted variant shares every input, only its enable is watched
    pwsq_sequencer #(.CYCLES_PER_MS(CPM), .ENABLE_ACTIVE_LOW(1'b1)) uutInv (.clock(clock), .rst_n(rst_n),
        .buttonN(buttonN), .sleepReq(sleepReq), .wakeIntervalMs(wakeIntervalMs),
        .shutdownHoldMs(shutdownHoldMs), .onTimeLimitMs(onTimeLimitMs), .enable(enableInv),
        .debouncedButtonOut(), .debouncedButtonOe(), .startupNoticeNOut(), .startupNoticeNOe(),
        .shutdownWarningNOut(), .shutdownWarningNOe());
    // power-up in shutdown; only its enable is watched
    pwsq_sequencer #(.CYCLES_PER_MS(CPM), .START_IN_SHUTDOWN(1'b1)) uutOff (.clock(clock), .rst_n(rst_n),
        .buttonN(buttonN), .sleepReq(sleepReq), .wakeIntervalMs(wakeIntervalMs),
        .shutdownHoldMs(shutdownHoldMs), .onTimeLimitMs(onTimeLimitMs), .enable(enableOff),
        .debouncedButtonOut(), .debouncedButtonOe(), .startupNoticeNOut(), .startupNoticeNOe(),
        .shutdownWarningNOut(), .shutdownWarningNOe());
    pwsq_host_model #(.CPM(CPM)) host (.clock(clock), .enable(enable), .taskMs(taskMs),
        .nudge(nudge), .sleepReq(sleepReq));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic inRange(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    function automatic logic pick(input int s);
        if (s == 0) return enable;
        if (s == 1) return btnOe;
        return warnOe;
    endfunction
    // bounded wait; the returned time is in whole ticks
    task automatic waitFor(input int s, input logic lvl, input int maxMs, output int ms);
        int n;
        n = 0;
        while (pick(s) !== lvl && n < maxMs * CPM) begin
            @(posedge clock);
            #2;
            n++;
        end
        ms = n / CPM;
        check("awaited level", 32'(lvl), 32'(pick(s)));
    endtask
    task automatic idleMs(input int n);
        repeat (n * CPM) @(posedge clock);
        #2;
    endtask
    task automatic quietMs(input int n);
        int hits;
        hits = 0;
        repeat (n * CPM) begin
            @(posedge clock);
            #2;
            if (enable !== 1'b0) hits++;
        end
        inRange("enable stayed off", 0, 0, hits);
    endtask
    task automatic pulseSleep();
        nudge = 1'b1;
        idleMs(1);
        nudge = 1'b0;
    endtask
    task automatic results();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic tReset();
        check("enable at reset", 0, 32'(enable));
        check("inverted enable at reset", 1, 32'(enableInv));
        check("alert enables", 0, 32'({btnOe, noticeOe, warnOe, btnOut, noticeOut, warnOut}));
        check("enable at power-up in shutdown", 0, 32'(enableOff));
    endtask
    task automatic tPeriodic();
        waitFor(0, 1'b1, 400, t1);
        check("inverted enable awake", 0, 32'(enableInv));
        check("shutdown start ignores period", 0, 32'(enableOff));
        waitFor(0, 1'b0, 40, t1);
        inRange("awake limit", 19, 21, t1);
        onTimeLimitMs = 16'h0000;
        waitFor(0, 1'b1, 300, t2);
        inRange("wake period", 199, 202, t1 + t2);
        waitFor(0, 1'b0, 40, t1);
        inRange("default awake limit", 7, 9, t1);
    endtask
    task automatic tActive();
        taskMs = 16'h000c;
        onTimeLimitMs = 16'h0064;
        waitFor(0, 1'b1, 250, t1);
        wakeIntervalMs = 32'h0000_1388;
        waitFor(0, 1'b0, 40, t1);
        inRange("host ends awake", 11, 13, t1);
        taskMs = 16'h0000;
        onTimeLimitMs = 16'h0014;
    endtask
    task automatic tSleepWake();
        idleMs(20);
        pulseSleep();
        quietMs(80);
        idleMs(40);
        pulseSleep();
        waitFor(0, 1'b1, 4, t1);
        inRange("sleep pin wake delay", 0, 3, t1);
        waitFor(0, 1'b0, 30, t1);
    endtask
    task automatic tButton();
        idleMs(140);
        buttonN = 1'b0;
        waitFor(1, 1'b1, 40, t1);
        inRange("press debounce", 31, 34, t1);
        idleMs(1);
        check("enable on press", 1, 32'(enable));
        check("press leaves power-up shutdown", 1, 32'(enableOff));
        check("button pin value", 0, 32'(btnOut));
        idleMs(15);
        buttonN = 1'b1;
        waitFor(1, 1'b0, 40, t1);
        inRange("release debounce", 31, 34, t1);
    endtask
    task automatic tShutdown();
        buttonN = 1'b0;
        waitFor(2, 1'b1, 200, t1);
        inRange("long hold", 158, 164, t1);
        buttonN = 1'b1;
        check("warning pin value", 0, 32'(warnOut));
        waitFor(2, 1'b0, 1100, t1);
        inRange("warning width", 999, 1001, t1);
        check("enable in off", 0, 32'(enable));
        pulseSleep();
        quietMs(20);
        buttonN = 1'b0;
        waitFor(0, 1'b1, 40, t1);
        inRange("press leaves off", 31, 34, t1);
        check("notice on", 1, 32'(noticeOe));
        check("notice pin value", 0, 32'(noticeOut));
        idleMs(10);
        check("notice held", 1, 32'(noticeOe));
        buttonN = 1'b1;
        waitFor(0, 1'b0, 30, t1);
        idleMs(1);
        check("notice cleared", 0, 32'(noticeOe));
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        $display("wrong value watchdog expected done seen hang");
        results();
    end
    initial begin
        rst_n = 1'b0;
        buttonN = 1'b1;
        nudge = 1'b0;
        taskMs = 16'h0000;
        wakeIntervalMs = 32'h0000_00c8;
        shutdownHoldMs = 16'h0080;
        onTimeLimitMs = 16'h0014;
        repeat (12) @(posedge clock);
        #2;
        rst_n = 1'b1;
        idleMs(1);
        tReset();
        tPeriodic();
        tActive();
        tSleepWake();
        tButton();
        tShutdown();
        results();
    end
endmodule // periodic_wake_power_sequencer_tb_top
